// ===== dv/sram_device_model.sv
// Purpose: behavioural 1K x 4 static RAM
// Assumes: pins move just after clock edges
// Notes:   reads show inverted data until access time
`timescale 1ns/100ps
module sram_device_model
    import sram_host_pkg::*;
(
    input  wire logic              i_clk_sys,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic              i_select_n,
    input  wire logic              i_write_n,
    input  wire logic [DATA_W-1:0] i_data,
    output logic [DATA_W-1:0]      o_data,
    output logic                   o_oe
);
    logic [DATA_W-1:0] mem_r [WORDS];
    int                age_r = 0;
    assign o_oe = !i_select_n && i_write_n;
    assign o_data = (age_r >= READ_CYC - 1) ? mem_r[i_addr] : ~mem_r[i_addr];
    always_ff @(posedge i_clk_sys) begin
        age_r <= i_select_n ? 0 : age_r + 1;
        if (!i_select_n && !i_write_n) mem_r[i_addr] <= i_data;
    end
endmodule : sram_device_model

// ===== dv/sram_host_checker.sv
// Purpose: pin timing checks on the RAM host
// Assumes: default cycle parameters
// Notes:   pulse and read lengths are counted at the default loads
`timescale 1ns/100ps
module sram_host_checker
    import sram_host_pkg::*;
#(
    parameter int WRITE_CYCLES = WRITE_CYC,
    parameter int READ_CYCLES  = READ_CYC
) (
    input wire logic              i_clk_sys,
    input wire logic              i_reset_n,
    input wire logic              o_req_ready,
    input wire logic              o_rsp_valid,
    input wire logic [ADDR_W-1:0] o_mem_addr,
    input wire logic              o_mem_select_n,
    input wire logic              o_mem_write_n,
    input wire logic [DATA_W-1:0] o_mem_data,
    input wire logic              o_mem_data_oe
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    sequence wr_s; (!o_mem_write_n && !o_mem_select_n)[*3]; endsequence
    sequence rd_s; (o_mem_write_n && !o_mem_select_n)[*5]; endsequence
    AST_WR_PULSE: assert property ($fell(o_mem_write_n) |-> wr_s ##1 (o_mem_write_n && o_mem_select_n))
        else $error("write pulse length");
    AST_RD_CYCLE: assert property ($fell(o_mem_select_n) && o_mem_write_n |-> rd_s ##1 (o_mem_select_n && o_rsp_valid))
        else $error("read cycle shape");
    AST_ADDR_HOLD: assert property (!o_mem_write_n |=> $stable(o_mem_addr)) else $error("addr moved");
    AST_ADDR_FIRST: assert property ($fell(o_mem_write_n) |-> $stable(o_mem_addr)) else $error("addr late");
    AST_OE_LATE: assert property ($fell(o_mem_write_n) |-> !o_mem_data_oe ##1 o_mem_data_oe) else $error("oe");
    AST_NO_CLASH: assert property (!o_mem_select_n && o_mem_write_n |-> !o_mem_data_oe) else $error("clash");
    AST_OVERLAP: assert property ($rose(o_mem_write_n) |-> $past(o_mem_data_oe, 2) &&
        $past(o_mem_data, 2) == $past(o_mem_data)) else $error("data overlap");
    AST_WR_DONE: assert property ($rose(o_mem_write_n) |=> o_rsp_valid && !o_mem_data_oe) else $error("done");
    AST_IDLE: assert property (o_req_ready |-> o_mem_select_n && o_mem_write_n && !o_mem_data_oe)
        else $error("idle pins");
endmodule : sram_host_checker
bind sram_host sram_host_checker #(.WRITE_CYCLES(WRITE_CYCLES), .READ_CYCLES(READ_CYCLES)) u_chk (.i_clk_sys,
    .i_reset_n, .o_req_ready, .o_rsp_valid, .o_mem_addr, .o_mem_select_n, .o_mem_write_n, .o_mem_data, .o_mem_data_oe);

// ===== dv/static_ram_1k_by_4_port_bench.sv
// Purpose: self-checking bench for the RAM host
// Assumes: model answers at slow grade timing
// Notes:   an undriven data port shows the inverse of the host word
`timescale 1ns/100ps
module static_ram_1k_by_4_port_bench
    import sram_host_pkg::*;
();
    logic              i_clk_sys = 1'b0, i_reset_n = 1'b0, vld = 1'b0, wr = 1'b0;
    logic [ADDR_W-1:0] adr = 10'h000, ma;
    logic [DATA_W-1:0] wd = 4'h0, q, md, dev_q;
    logic              rdy, rsp, sel_n, we_n, oe, dev_oe;
    wire  [DATA_W-1:0] bus = oe ? md : (dev_oe ? dev_q : ~md);
    int                err_count = 0;
    int                tests_run = 0;
    sram_host dut (.i_clk_sys, .i_reset_n, .i_req_valid(vld), .i_req_write(wr), .i_req_addr(adr),
        .i_req_wdata(wd), .o_req_ready(rdy), .o_rsp_valid(rsp), .o_rsp_rdata(q), .o_mem_addr(ma),
        .o_mem_select_n(sel_n), .o_mem_write_n(we_n), .o_mem_data(md), .o_mem_data_oe(oe), .i_mem_data(bus));
    sram_device_model dev (.i_clk_sys, .i_addr(ma), .i_select_n(sel_n), .i_write_n(we_n), .i_data(bus),
        .o_data(dev_q), .o_oe(dev_oe));
    initial forever #50 i_clk_sys = ~i_clk_sys;
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one request; q holds the answer on return
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        vld <= 1'b1;
        wr <= w;
        adr <= a;
        wd <= d;
        do @(posedge i_clk_sys); while (rdy !== 1'b1 && ++n < 40);
        vld <= 1'b0;
        do @(posedge i_clk_sys); while (rsp !== 1'b1 && ++n < 40);
        if (n >= 40) begin
            err_count++;
            conclude();
        end
    endtask : xfer
    task automatic t_codes();
        for (int i = 0; i < 16; i++) xfer(1'b1, ADDR_W'(i * 1023 / 15), DATA_W'(i));
        for (int i = 15; i >= 0; i--) begin
            xfer(1'b0, ADDR_W'(i * 1023 / 15), 4'h0);
            chk("word", q, DATA_W'(i));
        end
    endtask : t_codes
    task automatic t_overwrite();
        xfer(1'b1, 10'h3FF, 4'h5);
        xfer(1'b1, 10'h3FF, 4'hA);
        xfer(1'b0, 10'h3FF, 4'h0);
        chk("last write", q, 4'hA);
        xfer(1'b0, 10'h3FF, 4'h0);
        chk("reread", q, 4'hA);
    endtask : t_overwrite
    // reset lands inside a write interval
    task automatic t_reset();
        vld <= 1'b1;
        wr <= 1'b1;
        adr <= 10'h001;
        repeat (3) @(posedge i_clk_sys);
        vld <= 1'b0;
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        chk("idle pins", {sel_n, we_n, oe, rdy}, 4'hD);
        i_reset_n <= 1'b1;
        @(posedge i_clk_sys);
        xfer(1'b0, 10'h3BA, 4'h0);
        chk("kept word", q, 4'hE);
    endtask : t_reset
    initial begin
        repeat (6) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        @(posedge i_clk_sys);
        t_codes();
        t_overwrite();
        t_reset();
        conclude();
    end
endmodule : static_ram_1k_by_4_port_bench

// ===== rtl/sram_host.sv
// Purpose: host side controller driving a 1K x 4 static RAM through its pins
// Assumes: inputs synchronous to i_clk_sys; one request at a time
// Notes:   slowest grade timing, so any speed grade of part may be fitted
//          a write or a read returns to idle six cycles after it is taken
// Functional notes
// - strobe held high throughout a read cycle.
// - write pulse, last fall to first rise, at least the grade minimum.
// - address stable through write interval and release time.
// - never start the write interval before the address is valid.
// - write data stable for the overlap time before interval ends.
`timescale 1ns/100ps
module sram_host
    import sram_host_pkg::*;
#(
    parameter int WRITE_CYCLES = WRITE_CYC,
    parameter int READ_CYCLES  = READ_CYC
) (
    input  wire logic              i_clk_sys,
    input  wire logic              i_reset_n,
    // user request side
    input  wire logic              i_req_valid,
    input  wire logic              i_req_write,
    input  wire logic [ADDR_W-1:0] i_req_addr,
    input  wire logic [DATA_W-1:0] i_req_wdata,
    output logic                   o_req_ready,
    output logic                   o_rsp_valid,
    output logic [DATA_W-1:0]      o_rsp_rdata,
    // memory pins
    output logic [ADDR_W-1:0]      o_mem_addr,
    output logic                   o_mem_select_n,
    output logic                   o_mem_write_n,
    output logic [DATA_W-1:0]      o_mem_data,
    output logic                   o_mem_data_oe,
    input  wire logic [DATA_W-1:0] i_mem_data
);
    // one state per pin phase; turn gives the port time to float
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_WRITE,
        ST_RELEASE,
        ST_READ,
        ST_TURN
    } state_t;

    // -----------------------------------------------------------------
    // state and registers
    // -----------------------------------------------------------------
    state_t              state_r,   state_nxt;
    logic [3:0]          cnt_r,     cnt_nxt;
    logic [ADDR_W-1:0]   addr_r,    addr_nxt;
    logic [DATA_W-1:0]   wdata_r,   wdata_nxt;
    logic [DATA_W-1:0]   rdata_r,   rdata_nxt;
    logic                rsp_r,     rsp_nxt;
    logic                sel_n_r,   sel_n_nxt;
    logic                wr_n_r,    wr_n_nxt;
    logic                oe_r,      oe_nxt;

    // -----------------------------------------------------------------
    // cycle loads
    // -----------------------------------------------------------------
    // every figure rounds up to whole cycles, so a faster clock only
    // needs new package figures, never new sequencing
    localparam logic [3:0] WRITE_LOAD = 4'(WRITE_CYCLES);
    localparam logic [3:0] READ_LOAD  = 4'(READ_CYCLES > SEL_CYC ? READ_CYCLES : SEL_CYC);
    localparam logic [3:0] OFF_LOAD   = 4'(OFF_CYC);
    localparam logic [3:0] REL_LOAD   = 4'(RELEASE_CYC);
    // write data only goes out once the part has let go of the port,
    // so the pulse must cover that wait plus the whole overlap time
    localparam logic [3:0] OVL_LOAD   = 4'(OFF_CYC + OVERLAP_CYC);
    localparam logic [3:0] PULSE_LOAD = (OVL_LOAD > WRITE_LOAD) ? OVL_LOAD : WRITE_LOAD;

    // -----------------------------------------------------------------
    // counter and decode
    // -----------------------------------------------------------------
    // a load of one or zero both mean a single cycle in the state
    wire       st_idle  = (state_r == ST_IDLE);
    wire       cnt_done = (cnt_r == CNT_ONE) || (cnt_r == CNT_ZERO);
    wire       take     = i_req_valid && st_idle;
    wire [3:0] cnt_dec  = cnt_done ? CNT_ZERO : 4'(cnt_r - CNT_ONE);

    // -----------------------------------------------------------------
    // pin drive
    // -----------------------------------------------------------------
    // every pin comes from a flop, so no decode glitch reaches the part
    assign o_req_ready    = st_idle;
    assign o_rsp_valid    = rsp_r;
    assign o_rsp_rdata    = rdata_r;
    assign o_mem_addr     = addr_r;
    assign o_mem_select_n = sel_n_r;
    assign o_mem_write_n  = wr_n_r;
    assign o_mem_data     = wdata_r;
    assign o_mem_data_oe  = oe_r;

    // -----------------------------------------------------------------
    // sequencing
    // -----------------------------------------------------------------
    always_comb begin
        // pins hold and the answer pulse drops unless a state says otherwise
        state_nxt = state_r;
        cnt_nxt   = cnt_dec;
        // address reloads only in idle, so it outlives the interval
        addr_nxt  = addr_r;
        wdata_nxt = wdata_r;
        rdata_nxt = rdata_r;
        rsp_nxt   = 1'b0;
        sel_n_nxt = sel_n_r;
        wr_n_nxt  = wr_n_r;
        oe_nxt    = oe_r;
        unique case (state_r)
            ST_IDLE: begin
                // static part, nothing to do while idle
                sel_n_nxt = 1'b1;
                wr_n_nxt  = 1'b1;
                oe_nxt    = 1'b0;
                // a request waits at the caller until ready; none is refused
                if (take) begin
                    addr_nxt  = i_req_addr;
                    wdata_nxt = i_req_wdata;
                    // on a write, address settles one cycle before select falls; a read drops select with the address
                    state_nxt = i_req_write ? ST_SETUP : ST_READ;
                    cnt_nxt   = i_req_write ? CNT_ONE : READ_LOAD;
                    sel_n_nxt = i_req_write ? 1'b1 : 1'b0;
                end
            end
            ST_SETUP: begin
                // address has stood a full cycle by now
                // select and strobe fall together with address stable
                sel_n_nxt = 1'b0;
                wr_n_nxt  = 1'b0;
                // drive only after the device has let go
                oe_nxt    = 1'b0;
                // pulse covers release wait and overlap
                cnt_nxt   = PULSE_LOAD;
                state_nxt = ST_WRITE;
            end
            ST_WRITE: begin
                // data out one cycle after the fall, held to the end
                oe_nxt = 1'b1;
                if (cnt_done) begin
                    // pulse spans at least the minimum width
                    sel_n_nxt = 1'b1;
                    wr_n_nxt  = 1'b1;
                    cnt_nxt   = REL_LOAD;
                    state_nxt = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                // address and data held past the rising edges
                // hold time is zero; one spare cycle costs little
                if (cnt_done) begin
                    oe_nxt    = 1'b0;
                    rsp_nxt   = 1'b1;
                    state_nxt = ST_TURN;
                    cnt_nxt   = CNT_ONE;
                end
            end
            ST_READ: begin
                // sample after access and select times
                if (cnt_done) begin
                    rdata_nxt = i_mem_data;
                    rsp_nxt   = 1'b1;
                    sel_n_nxt = 1'b1;
                    // let the device turn off before next access
                    cnt_nxt   = OFF_LOAD;
                    state_nxt = ST_TURN;
                end
            end
            ST_TURN: begin
                // gap so a deselected part has floated its outputs
                if (cnt_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // -----------------------------------------------------------------
    // register update
    // -----------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            // a reset mid-write cuts the pulse; that word may be lost
            state_r <= ST_IDLE;
            cnt_r   <= CNT_ZERO;
            addr_r  <= '0;
            wdata_r <= '0;
            rdata_r <= '0;
            rsp_r   <= 1'b0;
            // deselected and strobe high keep the port quiet
            sel_n_r <= 1'b1;
            wr_n_r  <= 1'b1;
            oe_r    <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            addr_r  <= addr_nxt;
            wdata_r <= wdata_nxt;
            rdata_r <= rdata_nxt;
            rsp_r   <= rsp_nxt;
            sel_n_r <= sel_n_nxt;
            wr_n_r  <= wr_n_nxt;
            oe_r    <= oe_nxt;
        end
    end
endmodule : sram_host

// ===== rtl/sram_host_pkg.sv
// Purpose: constants for the host controller of a 1K x 4 static RAM
// Assumes: 10 MHz system clock
// Notes:   times in ns, cycle counts derived from them
package sram_host_pkg;
    localparam int        CLK_PERIOD_NS        = 100;
    localparam int        ADDR_W               = 10;
    localparam int        DATA_W               = 4;
    localparam int        WORDS                = 1024;
    // slow grade figures
    localparam int        WRITE_PULSE_WIDTH_NS = 200;
    localparam int        DATA_OVERLAP_TIME_NS = 200;
    localparam int        WRITE_RELEASE_NS     = 0;
    localparam int        ACCESS_TIME_NS       = 450;
    localparam int        SELECT_TO_VALID_NS   = 120;
    localparam int        OUTPUT_OFF_NS        = 100;
    // least times round up, at least one cycle
    localparam int        WRITE_CYC   = (WRITE_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int        OVERLAP_CYC = (DATA_OVERLAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int        RELEASE_CYC = (WRITE_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int        READ_CYC    = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int        SEL_CYC     = (SELECT_TO_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int        OFF_CYC     = (OUTPUT_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] CNT_ZERO   = 4'h0;
    localparam logic [3:0] CNT_ONE    = 4'h1;
endpackage : sram_host_pkg
